// file: escnt_pkg.sv
// Constants shared by the statistics counter block
// Assumes a 32-bit double-word register port decoded by byte offset
package escnt_pkg;
    // Register byte offsets
    localparam logic [7:0]  OFS_BCST_TX_OCTET = 8'hD8;
    localparam logic [7:0]  OFS_XCOL_ABORT    = 8'hFC;
    localparam logic [7:0]  OFS_CARRIER_LOSS  = 8'hF0;
    localparam logic [7:0]  OFS_FCS_FAILURE   = 8'hCC;
    // Values after reset
    localparam logic [31:0] RST_OCTET         = 32'h0000_0000;
    localparam logic [15:0] RST_FRAME         = 16'h0000;
    // Thresholds that raise the statistics flag
    localparam logic [31:0] THR_OCTET         = 32'hC000_0000;
    localparam logic [15:0] THR_FRAME         = 16'hC000;
    // Octets in a VLAN tag
    localparam logic [31:0] VLAN_TAG_OCTETS   = 32'h0000_0004;
    // Mask bit positions
    localparam int          MSK_BCST_TX_OCTET = 0;
    localparam int          MSK_CARRIER_LOSS  = 1;
    localparam int          MSK_XCOL_ABORT    = 2;
    localparam int          MSK_FCS_FAILURE   = 3;
endpackage

// file: escnt_stats.sv
// Four MAC statistics counters with register access and threshold flag
// Assumes MAC event inputs on CLK_SYS; carrier sense arrives from a pin
`timescale 1ns/100ps

// What this block does
// R1 - Add each good broadcast frame's data and pad octets to the octet counter
// R2 - Octet counter wraps to zero after its 32-bit maximum
// R3 - Octet counts add the four VLAN tag octets only when the tag is inserted
// R4 - Octet counter reaching 0xC0000000 raises the statistics flag
// R5 - Counter runs only with global enable high and its mask bit low
// R6 - Count carrier sense dropping during a collision-free transmission
// R7 - Ignore carrier sense until preamble and delimiter are sent
// R8 - Carrier loss counter wraps at 0xFFFF, flags at 0xC000
// R9 - Count frames abandoned for excess collisions, wrap and flag likewise
// R10 - Count whole-octet received frames failing FCS, not too long or runt
// R11 - FCS failure counter wraps at 0xFFFF, flags at 0xC000
// R12 - Flag once, on the increment that reaches the threshold
module escnt_stats (
    // Clock and reset
    input  wire logic        CLK_SYS,
    input  wire logic        RESET,
    // Register port
    input  wire logic [7:0]  REG_ADDR,
    input  wire logic        REG_WR,
    input  wire logic        REG_RD,
    input  wire logic [31:0] REG_WDATA,
    output logic      [31:0] REG_RDATA,
    // Counter enables
    input  wire logic        COUNTER_GLOBAL_ENABLE,
    input  wire logic [3:0]  COUNTER_MASK,
    // Transmit events
    input  wire logic        TX_BCST_OK,
    input  wire logic [15:0] TX_BCST_OCTETS,
    input  wire logic        TX_VLAN_INSERTED,
    input  wire logic        TX_ACTIVE,
    input  wire logic        TX_SFD_DONE,
    input  wire logic        TX_COLLISION,
    input  wire logic        TX_XCOL_ABORT,
    input  wire logic        CRS,
    // Receive events
    input  wire logic        RX_DONE,
    input  wire logic        RX_FCS_BAD,
    input  wire logic        RX_ODD_BITS,
    input  wire logic        RX_TOO_LONG,
    input  wire logic        RX_RUNT,
    // Statistics flag pulse toward the interrupt status
    output logic             STATS_THRESHOLD_FLAG
);

    ////////////////////////////////////////////////////////////////////////
    // State
    logic [31:0] octet_ff,   nxt_octet;
    logic [15:0] carrier_ff, nxt_carrier;
    logic [15:0] xcol_ff,    nxt_xcol;
    logic [15:0] fcs_ff,     nxt_fcs;
    logic [31:0] rdata_ff,   nxt_rdata;
    logic        flag_ff,    nxt_flag;
    logic        crs_m_ff;
    logic        crs_s_ff;
    logic        crs_d_ff;
    logic [3:0]  act;
    logic [31:0] octet_add;
    logic        inc_oct;
    logic        inc_car;
    logic        inc_xcol;
    logic        inc_fcs;
    logic        wr_oct;
    logic        wr_car;
    logic        wr_xcol;
    logic        wr_fcs;

    ////////////////////////////////////////////////////////////////////////
    // Carrier sense synchroniser and delayed copy for edge detection
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            crs_m_ff <= 1'b0;
            crs_s_ff <= 1'b0;
            crs_d_ff <= 1'b0;
        end else begin
            crs_m_ff <= CRS;
            crs_s_ff <= crs_m_ff;
            crs_d_ff <= crs_s_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Counter activity and qualified events
    always_comb begin
        act       = {4{COUNTER_GLOBAL_ENABLE}} & ~COUNTER_MASK; // R5
        octet_add = {16'h0000, TX_BCST_OCTETS};                  // R1
        if (TX_VLAN_INSERTED) begin
            octet_add = octet_add + escnt_pkg::VLAN_TAG_OCTETS;  // R3
        end
        // A write to a counter in the same cycle drops its event and flag
        wr_oct   = REG_WR && REG_ADDR == escnt_pkg::OFS_BCST_TX_OCTET;
        wr_car   = REG_WR && REG_ADDR == escnt_pkg::OFS_CARRIER_LOSS;
        wr_xcol  = REG_WR && REG_ADDR == escnt_pkg::OFS_XCOL_ABORT;
        wr_fcs   = REG_WR && REG_ADDR == escnt_pkg::OFS_FCS_FAILURE;
        inc_oct  = TX_BCST_OK & act[escnt_pkg::MSK_BCST_TX_OCTET] & ~wr_oct;
        inc_car  = act[escnt_pkg::MSK_CARRIER_LOSS] & TX_ACTIVE
                   & TX_SFD_DONE & ~TX_COLLISION                 // R7
                   & crs_d_ff & ~crs_s_ff & ~wr_car;             // R6
        inc_xcol = TX_XCOL_ABORT & act[escnt_pkg::MSK_XCOL_ABORT]
                   & ~wr_xcol;                                   // R9
        inc_fcs  = RX_DONE & RX_FCS_BAD & ~RX_ODD_BITS & ~RX_TOO_LONG
                   & ~RX_RUNT & act[escnt_pkg::MSK_FCS_FAILURE]  // R10
                   & ~wr_fcs;
    end

    ////////////////////////////////////////////////////////////////////////
    // Next counter values, flag and read data; a write wins over a count
    always_comb begin
        nxt_octet   = octet_ff;
        nxt_carrier = carrier_ff;
        nxt_xcol    = xcol_ff;
        nxt_fcs     = fcs_ff;
        nxt_flag    = 1'b0;
        nxt_rdata   = rdata_ff;
        // Octet counter, modular add wraps past the maximum
        if (inc_oct) begin
            nxt_octet = octet_ff + octet_add;                    // R2
            if (octet_ff < escnt_pkg::THR_OCTET
                && nxt_octet >= escnt_pkg::THR_OCTET
                && nxt_octet > octet_ff) begin
                nxt_flag = 1'b1;                                 // R4
            end
        end
        // Frame counters, flag only on the step onto the threshold
        if (inc_car) begin
            nxt_carrier = carrier_ff + 16'h0001;                 // R8
            if (nxt_carrier == escnt_pkg::THR_FRAME) begin
                nxt_flag = 1'b1;                                 // R12
            end
        end
        if (inc_xcol) begin
            nxt_xcol = xcol_ff + 16'h0001;                       // R9
            if (nxt_xcol == escnt_pkg::THR_FRAME) begin
                nxt_flag = 1'b1;
            end
        end
        if (inc_fcs) begin
            nxt_fcs = fcs_ff + 16'h0001;                         // R11
            if (nxt_fcs == escnt_pkg::THR_FRAME) begin
                nxt_flag = 1'b1;
            end
        end
        // Software writes
        if (REG_WR) begin
            case (REG_ADDR)
                escnt_pkg::OFS_BCST_TX_OCTET: nxt_octet   = REG_WDATA;
                escnt_pkg::OFS_CARRIER_LOSS:  nxt_carrier = REG_WDATA[15:0];
                escnt_pkg::OFS_XCOL_ABORT:    nxt_xcol    = REG_WDATA[15:0];
                escnt_pkg::OFS_FCS_FAILURE:   nxt_fcs     = REG_WDATA[15:0];
                default: ;
            endcase
        end
        // Software reads, unmapped offsets read zero
        if (REG_RD) begin
            case (REG_ADDR)
                escnt_pkg::OFS_BCST_TX_OCTET: nxt_rdata = octet_ff;
                escnt_pkg::OFS_CARRIER_LOSS:
                    nxt_rdata = {16'h0000, carrier_ff};
                escnt_pkg::OFS_XCOL_ABORT:    nxt_rdata = {16'h0000, xcol_ff};
                escnt_pkg::OFS_FCS_FAILURE:   nxt_rdata = {16'h0000, fcs_ff};
                default:                      nxt_rdata = 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register stage
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            octet_ff   <= escnt_pkg::RST_OCTET;
            carrier_ff <= escnt_pkg::RST_FRAME;
            xcol_ff    <= escnt_pkg::RST_FRAME;
            fcs_ff     <= escnt_pkg::RST_FRAME;
            rdata_ff   <= 32'h0000_0000;
            flag_ff    <= 1'b0;
        end else begin
            octet_ff   <= nxt_octet;
            carrier_ff <= nxt_carrier;
            xcol_ff    <= nxt_xcol;
            fcs_ff     <= nxt_fcs;
            rdata_ff   <= nxt_rdata;
            flag_ff    <= nxt_flag;
        end
    end

    // Outputs straight from flip-flops
    assign REG_RDATA            = rdata_ff;
    assign STATS_THRESHOLD_FLAG = flag_ff;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    oct_add_a: assert property (@(posedge CLK_SYS) disable iff (RESET) // R1
        (TX_BCST_OK && act[0] && !REG_WR && !TX_VLAN_INSERTED)
        |=> octet_ff == $past(octet_ff) + {16'h0000, $past(TX_BCST_OCTETS)})
        else $error("octet counter did not add frame octets");
    oct_wrap_a: assert property (@(posedge CLK_SYS) disable iff (RESET) // R2
        (octet_ff == 32'hFFFF_FFFF && inc_oct && !REG_WR
         && TX_BCST_OCTETS == 16'h0001 && !TX_VLAN_INSERTED)
        |=> octet_ff == 32'h0000_0000)
        else $error("octet counter did not wrap");
    vlan_add_a: assert property (@(posedge CLK_SYS) disable iff (RESET) // R3
        (inc_oct && TX_VLAN_INSERTED && !REG_WR)
        |=> octet_ff == $past(octet_ff) + $past(octet_add)
            && $past(octet_add) == {16'h0000, $past(TX_BCST_OCTETS)}
               + escnt_pkg::VLAN_TAG_OCTETS)
        else $error("VLAN octets not counted");
    oct_thr_a: assert property (@(posedge CLK_SYS) disable iff (RESET) // R4
        (inc_oct && !REG_WR && octet_ff == 32'hBFFF_FFFF
         && TX_BCST_OCTETS == 16'h0001 && !TX_VLAN_INSERTED)
        |=> STATS_THRESHOLD_FLAG)
        else $error("octet threshold flag missing");
    gate_off_a: assert property (@(posedge CLK_SYS) disable iff (RESET) // R5
        (!COUNTER_GLOBAL_ENABLE && !REG_WR) |=> $stable(carrier_ff)
            && $stable(xcol_ff) && $stable(fcs_ff) && $stable(octet_ff))
        else $error("counter moved while disabled");
    car_edge_a: assert property (@(posedge CLK_SYS) disable iff (RESET) // R7
        (!REG_WR && (!TX_SFD_DONE || TX_COLLISION)) |=> $stable(carrier_ff))
        else $error("carrier loss counted before delimiter or in collision");
    car_wrap_a: assert property (@(posedge CLK_SYS) disable iff (RESET) // R8
        (inc_car && !REG_WR && carrier_ff == 16'hFFFF)
        |=> carrier_ff == 16'h0000 && !STATS_THRESHOLD_FLAG)
        else $error("carrier loss counter wrap wrong");
    xcol_cnt_a: assert property (@(posedge CLK_SYS) disable iff (RESET) // R9
        (inc_xcol && !REG_WR)
        |=> xcol_ff == $past(xcol_ff) + 16'h0001)
        else $error("excess collision abort not counted");
    fcs_excl_a: assert property (@(posedge CLK_SYS) disable iff (RESET) // R10
        (!REG_WR && (RX_TOO_LONG || RX_RUNT || RX_ODD_BITS))
        |=> $stable(fcs_ff))
        else $error("excluded frame counted as FCS failure");
    fcs_thr_a: assert property (@(posedge CLK_SYS) disable iff (RESET) // R11
        (inc_fcs && !REG_WR && fcs_ff == 16'hBFFF)
        |=> fcs_ff == 16'hC000 ##0 STATS_THRESHOLD_FLAG)
        else $error("FCS threshold not flagged");
    flag_once_a: assert property (@(posedge CLK_SYS) disable iff (RESET) // R12
        (!inc_oct && !REG_WR && carrier_ff > 16'hC000 && xcol_ff > 16'hC000
         && fcs_ff > 16'hC000 && carrier_ff != 16'hFFFF && xcol_ff != 16'hFFFF
         && fcs_ff != 16'hFFFF) |=> !STATS_THRESHOLD_FLAG)
        else $error("flag repeated above threshold");
    xcol_once_a: assert property (@(posedge CLK_SYS) disable iff (RESET) // R12
        (inc_xcol && !inc_oct && !inc_car && !inc_fcs
         && xcol_ff >= escnt_pkg::THR_FRAME && xcol_ff != 16'hFFFF)
        |=> !STATS_THRESHOLD_FLAG)
        else $error("abort counter flagged again above threshold");
    xcol_wr_a: assert property (@(posedge CLK_SYS) disable iff (RESET) // R9
        (REG_WR && REG_ADDR == escnt_pkg::OFS_XCOL_ABORT)
        |=> xcol_ff == $past(REG_WDATA[15:0]))
        else $error("abort counter write did not win");
endmodule

// file: escnt_stats_test.sv
// Self-checking bench for the four statistics counters
// Assumes escnt_pkg and escnt_stats are compiled before this file
`timescale 1ns/100ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin mismatches++; \
    $display("Error %0t: got %h want %h", $time, a, e); end end
module ethernet_statistics_counters_test;
    logic        clk = 0, rst = 1, wr = 0, rd = 0, gen = 1, vlan = 0;
    logic        bok = 0, act = 0, sfd = 0, col = 0, xab = 0, crs = 1;
    logic        rxd = 0, fcs = 0, odd = 0, lng = 0, runt = 0;
    logic [7:0]  adr = 0;
    logic [31:0] wd = 0;
    logic [3:0]  msk = 0;
    logic [15:0] oct = 0;
    logic [31:0] rdat;
    logic        flag;
    int          mismatches = 0, n_tests = 0;
    ////////////////////////////////////////////////////////////////////////
    // Device under test
    escnt_stats escnt_stats_inst (.CLK_SYS(clk), .RESET(rst),
        .REG_ADDR(adr), .REG_WR(wr), .REG_RD(rd), .REG_WDATA(wd),
        .REG_RDATA(rdat), .COUNTER_GLOBAL_ENABLE(gen), .COUNTER_MASK(msk),
        .TX_BCST_OK(bok), .TX_BCST_OCTETS(oct), .TX_VLAN_INSERTED(vlan),
        .TX_ACTIVE(act), .TX_SFD_DONE(sfd), .TX_COLLISION(col),
        .TX_XCOL_ABORT(xab), .CRS(crs), .RX_DONE(rxd), .RX_FCS_BAD(fcs),
        .RX_ODD_BITS(odd), .RX_TOO_LONG(lng), .RX_RUNT(runt),
        .STATS_THRESHOLD_FLAG(flag));
    // Free-running 20 MHz clock
    initial begin
        forever #25 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////
    // Shared register and event helpers, driven on the falling edge
    task wreg(input logic [7:0] a, input logic [31:0] d);
        @(negedge clk); adr = a; wd = d; wr = 1;
        @(negedge clk); wr = 0;
    endtask
    task creg(input logic [7:0] a, input logic [31:0] e);
        @(negedge clk); adr = a; rd = 1;
        @(negedge clk); rd = 0;
        `CHK(rdat, e)
    endtask
    // One-cycle event pulse; flag is settled by the next falling edge
    task ev(input logic b, input logic x, input logic r, input logic fe);
        @(negedge clk); bok = b; xab = x; rxd = r;
        @(negedge clk); bok = 0; xab = 0; rxd = 0;
        `CHK(flag, fe)
    endtask
    task hold(input int n);
        repeat (n) @(negedge clk);
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Scenarios
    task t_reset;
        creg(escnt_pkg::OFS_BCST_TX_OCTET, 32'h0000_0000);
        creg(escnt_pkg::OFS_XCOL_ABORT, 32'h0000_0000);
        creg(escnt_pkg::OFS_CARRIER_LOSS, 32'h0000_0000);
        creg(escnt_pkg::OFS_FCS_FAILURE, 32'h0000_0000);
        creg(8'h00, 32'h0000_0000);
    endtask
    task t_octet;
        wreg(escnt_pkg::OFS_BCST_TX_OCTET, 32'hBFFF_FFF0);
        vlan = 1; oct = 16'h000C;
        ev(1, 0, 0, 1);
        vlan = 0; oct = 16'h0004;
        ev(1, 0, 0, 0);
        creg(escnt_pkg::OFS_BCST_TX_OCTET, 32'hC000_0004);
        wreg(escnt_pkg::OFS_BCST_TX_OCTET, 32'hFFFF_FFFE);
        oct = 16'h0003;
        ev(1, 0, 0, 0);
        creg(escnt_pkg::OFS_BCST_TX_OCTET, 32'h0000_0001);
    endtask
    task t_xcol;
        wreg(escnt_pkg::OFS_XCOL_ABORT, 32'h0000_BFFF);
        ev(0, 1, 0, 1);
        ev(0, 1, 0, 0);
        wreg(escnt_pkg::OFS_XCOL_ABORT, 32'h0000_FFFF);
        ev(0, 1, 0, 0);
        creg(escnt_pkg::OFS_XCOL_ABORT, 32'h0000_0000);
    endtask
    // Write and abort event in one cycle: the write wins, no flag
    task t_clash;
        wreg(escnt_pkg::OFS_XCOL_ABORT, 32'h0000_BFFF);
        @(negedge clk);
        adr = escnt_pkg::OFS_XCOL_ABORT;
        wd = 32'h0000_0005;
        wr = 1;
        xab = 1;
        @(negedge clk);
        wr = 0;
        xab = 0;
        `CHK(flag, 1'b0)
        creg(escnt_pkg::OFS_XCOL_ABORT, 32'h0000_0005);
    endtask
    task t_fcs;
        wreg(escnt_pkg::OFS_FCS_FAILURE, 32'hFFFF_BFFF);
        fcs = 1;
        ev(0, 0, 1, 1);
        odd = 1; ev(0, 0, 1, 0);
        odd = 0; lng = 1; ev(0, 0, 1, 0);
        lng = 0; runt = 1; ev(0, 0, 1, 0);
        runt = 0; fcs = 0; ev(0, 0, 1, 0);
        creg(escnt_pkg::OFS_FCS_FAILURE, 32'h0000_C000);
        wreg(escnt_pkg::OFS_FCS_FAILURE, 32'h0000_FFFF);
        fcs = 1; ev(0, 0, 1, 0);
        fcs = 0;
        creg(escnt_pkg::OFS_FCS_FAILURE, 32'h0000_0000);
    endtask
    // Carrier drops before delimiter, during collision, then counted once
    task t_carrier;
        act = 1; hold(4); crs = 0; hold(6); crs = 1; hold(4);
        col = 1; sfd = 1; crs = 0; hold(6); crs = 1; hold(4);
        col = 0; crs = 0; hold(6); crs = 1; act = 0; sfd = 0;
        creg(escnt_pkg::OFS_CARRIER_LOSS, 32'h0000_0001);
    endtask
    task t_enable;
        msk = 4'b0001; oct = 16'h0008; ev(1, 0, 0, 0);
        msk = 4'b0000; gen = 0; fcs = 1; ev(0, 0, 1, 0);
        gen = 1; fcs = 0;
        creg(escnt_pkg::OFS_BCST_TX_OCTET, 32'h0000_0001);
        creg(escnt_pkg::OFS_FCS_FAILURE, 32'h0000_0000);
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Verdict and run control
    task finish_test;
        if (mismatches == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Watchdog, far beyond the roughly 110 cycles the tests take
    initial begin
        #1000000;
        mismatches++;
        finish_test();
    end
    initial begin
        hold(10); rst = 0;
        t_reset(); t_octet(); t_xcol(); t_clash();
        t_fcs(); t_carrier(); t_enable();
        finish_test();
    end
endmodule
